// *** hw/via_regs.svh ***
/*
 * Constants of the vectored interrupt acknowledge block: register select
 * codes, status word field positions, reset values and entry timing.
 * Assumes it is included by bare name from via_ack_top, the only file that includes it.
 */
`ifndef VIA_REGS_SVH
`define VIA_REGS_SVH

// ***********************************************************************
// Register select codes on the core-side register port
// ***********************************************************************
`define VIA_SEL_PSW 2'h0
`define VIA_SEL_REQ 2'h1
`define VIA_SEL_MASK 2'h2
`define VIA_SEL_LEVEL 2'h3

// ***********************************************************************
// Status word fields and reset values
// ***********************************************************************
`define VIA_ACCEPT_BIT 7
`define VIA_INSVC_BIT 1
`define VIA_PSW_RESET 8'h02
`define VIA_FLAG_RESET 32'hFFFFFFFF
`define VIA_TRAP_VECTOR 16'h003E

// ***********************************************************************
// Entry timing in CPU clocks
// ***********************************************************************
`define VIA_LAT_MIN_HI 7
`define VIA_LAT_MIN_LO 8
`define VIA_LAT_MAX_HI 32
`define VIA_LAT_MAX_LO 33
`define VIA_ENTRY_FIXED 5

`endif

// *** hw/via_pkg.sv ***
/*
 * Types shared by the vectored interrupt acknowledge block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package via_pkg;

  typedef enum logic [2:0] {
    VIA_ST_IDLE = 3'b000,
    VIA_ST_WAIT = 3'b001,
    VIA_ST_PSW = 3'b010,
    VIA_ST_PC = 3'b011,
    VIA_ST_VEC = 3'b100
  } via_state_t;

  typedef logic [1:0] via_sel_t;

endpackage

// *** hw/via_pick_if.sv ***
/*
 * Carrier between the acknowledge top and its request picker.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface via_pick_if #(
  parameter int N_SRC = 8,
  parameter int IW = 3
);
  logic [N_SRC-1:0] req;
  logic [N_SRC-1:0] mask;
  logic [N_SRC-1:0] lvl;
  logic accept;
  logic insvc;
  logic found;
  logic [IW-1:0] idx;
  logic lvl_hit;

  modport top (output req, output mask, output lvl, output accept,
               output insvc, input found, input idx, input lvl_hit);
  modport pick (input req, input mask, input lvl, input accept,
                input insvc, output found, output idx, output lvl_hit);
endinterface

`default_nettype wire

// *** hw/via_pick.sv ***
/*
 * Request picker: finds the acknowledgeable maskable request with the
 * best level, ties broken by source index (lowest index first).
 * Assumes flags come from registers on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module via_pick #(
  parameter int N_SRC = 8,
  parameter int IW = 3
) (
  via_pick_if.pick p
);

  logic [N_SRC-1:0] elig;

  // ***********************************************************************
  // Per-source eligibility
  // ***********************************************************************
  for (genvar g = 0; g < N_SRC; g++) begin : g_elig
    assign elig[g] = p.req[g] & ~p.mask[g]
                     & p.accept
                     & (~p.lvl[g] | p.insvc);
  end

  // ***********************************************************************
  // Level first, then fixed index order
  // ***********************************************************************
  always_comb begin
    logic found_hi;
    logic found_lo;
    logic [IW-1:0] idx_hi;
    logic [IW-1:0] idx_lo;
    found_hi = 1'b0;
    found_lo = 1'b0;
    idx_hi = '0;
    idx_lo = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (elig[i] && !p.lvl[i]) begin
        found_hi = 1'b1;
        idx_hi = IW'(i);
      end
      if (elig[i] && p.lvl[i]) begin
        found_lo = 1'b1;
        idx_lo = IW'(i);
      end
    end
    p.found = found_hi | found_lo;
    p.idx = found_hi ? idx_hi : idx_lo;
    p.lvl_hit = ~found_hi;
  end

endmodule // via_pick

`default_nettype wire

// *** hw/via_ack_top.sv ***
/*
 * Vectored interrupt acknowledge logic of an 8-bit core: request, mask
 * and level flags, the processor status word, the acknowledge decision
 * at instruction boundaries and the entry sequence (push status word,
 * push program counter, load vector).
 * Assumes the core reports each instruction end with its class, stalls
 * while busy_o is high and pushes the program counter on stk_pc_o.
 */
// Functional notes
// - Acknowledgeable when request set and unmasked
// - Vectored acknowledge only while accept flag set
// - In-service flag 0 blocks low-level requests
// - Latency 7..32 clocks, or 8..33 at low
// - Divide may stretch latency past maximum
// - Better level first, then fixed default order
// - Untaken requests stay pending until acknowledgeable
// - Entry pushes status, PC, clears accept, vectors
// - Return-from-interrupt restores PC and status word
// - Trap instruction: unmaskable entry through 003EH vector
// - Reset loads status word with 02H
// - Status word: byte, bit, accept instructions, push/pop
// - Nest equal or higher level when accepting
// - In-service 0: only high level nests
// - One instruction runs after return before acknowledge
// - Hold instructions defer acknowledge one more instruction
// - Trap does not defer; it clears accept
// - Request setting ignores level flag
// - Level 0 high; in-service 0 means high servicing
// - Reset sets mask and level flags all ones
`timescale 1ns/1ps
`default_nettype none
`include "via_regs.svh"

module via_ack_top #(
  parameter int N_SRC = 8,
  parameter logic [15:0] VEC_BASE = 16'h0004,
  parameter logic [15:0] VEC_STEP = 16'h0002
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Peripheral request pulses
  input wire logic [N_SRC-1:0] src_req_i,
  // Core instruction boundary
  input wire logic instr_end_i,
  input wire logic instr_hold_i,
  input wire logic op_brk_i,
  input wire logic op_return_from_interrupt_i,
  input wire logic op_return_from_trap_i,
  input wire logic op_ei_i,
  input wire logic op_di_i,
  // Core register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire via_pkg::via_sel_t reg_sel_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_wmask_i,
  input wire logic restore_i,
  input wire logic [7:0] restore_data_i,
  output logic [31:0] reg_rdata_o,
  // Status word
  output logic [7:0] psw_o,
  // Entry sequence towards the core
  output logic busy_o,
  output logic stk_wr_o,
  output logic stk_pc_o,
  output logic [7:0] stk_data_o,
  output logic vec_load_o,
  output logic [15:0] vec_addr_o
);

  localparam int IW = (N_SRC > 1) ? $clog2(N_SRC) : 1;
  localparam logic [2:0] WAIT_HI = 3'(`VIA_LAT_MIN_HI - `VIA_ENTRY_FIXED);
  localparam logic [2:0] WAIT_LO = 3'(`VIA_LAT_MIN_LO - `VIA_ENTRY_FIXED);
  localparam logic [31:0] FLAG_RST = `VIA_FLAG_RESET;

  if (N_SRC < 1 || N_SRC > 32) begin : g_chk
    $error("N_SRC must lie between 1 and 32");
  end

  // ***********************************************************************
  // Declarations
  // ***********************************************************************
  logic [N_SRC-1:0] req_q;
  logic [N_SRC-1:0] mask_q;
  logic [N_SRC-1:0] lvl_q;
  logic [7:0] psw_q;
  via_pkg::via_state_t state_q;
  logic [2:0] cnt_q;
  logic sel_sw_q;
  logic sel_lvl_q;
  logic [IW-1:0] sel_idx_q;
  logic acc_q;
  logic busy_q;
  logic stk_wr_q;
  logic stk_pc_q;
  logic [7:0] stk_data_q;
  logic vec_load_q;
  logic [15:0] vec_addr_q;
  logic [31:0] rdata_q;
  logic hold_now;
  logic take_sw;
  logic take_mk;
  logic [N_SRC-1:0] ack_clr;
  logic wr_req;
  logic wr_mask;
  logic wr_lvl;
  logic wr_psw;

  via_pick_if #(.N_SRC(N_SRC), .IW(IW)) pk ();

  via_pick #(.N_SRC(N_SRC), .IW(IW)) u_pick (
    .p(pk)
  );

  assign pk.req = req_q;
  assign pk.mask = mask_q;
  assign pk.lvl = lvl_q;
  assign pk.accept = psw_q[`VIA_ACCEPT_BIT];
  assign pk.insvc = psw_q[`VIA_INSVC_BIT];

  // ***********************************************************************
  // Acknowledge decision
  // ***********************************************************************
  assign wr_req = reg_wr_i && (reg_sel_i == `VIA_SEL_REQ);
  assign wr_mask = reg_wr_i && (reg_sel_i == `VIA_SEL_MASK);
  assign wr_lvl = reg_wr_i && (reg_sel_i == `VIA_SEL_LEVEL);
  assign wr_psw = reg_wr_i && (reg_sel_i == `VIA_SEL_PSW);

  // Instruction ending now touched flags, status word or acceptance
  assign hold_now = instr_hold_i | op_return_from_interrupt_i | op_return_from_trap_i
                    | op_ei_i | op_di_i | acc_q
                    | reg_wr_i | reg_rd_i | restore_i;

  assign take_sw = (state_q == via_pkg::VIA_ST_IDLE)
                   && instr_end_i && op_brk_i;
  // Not taken leaves the flag set, so it is retried each boundary
  assign take_mk = (state_q == via_pkg::VIA_ST_IDLE)
                   && instr_end_i && !op_brk_i
                   && !hold_now && pk.found;

  // Register accesses seen within the current instruction
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_q <= 1'b0;
    end else if (instr_end_i) begin
      acc_q <= 1'b0;
    end else if (reg_wr_i || reg_rd_i || restore_i) begin
      acc_q <= 1'b1;
    end
  end

  // ***********************************************************************
  // Request, mask and level flags
  // ***********************************************************************
  for (genvar g = 0; g < N_SRC; g++) begin : g_flag
    assign ack_clr[g] = take_mk && (pk.idx == IW'(g));

    // Set wins over software or acknowledge clear
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        req_q[g] <= 1'b0;
      end else if (src_req_i[g]) begin
        req_q[g] <= 1'b1;
      end else if (ack_clr[g]) begin
        req_q[g] <= 1'b0;
      end else if (wr_req && reg_wmask_i[g]) begin
        req_q[g] <= reg_wdata_i[g];
      end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        mask_q[g] <= FLAG_RST[g];
        lvl_q[g] <= FLAG_RST[g];
      end else begin
        if (wr_mask && reg_wmask_i[g]) begin
          mask_q[g] <= reg_wdata_i[g];
        end
        if (wr_lvl && reg_wmask_i[g]) begin
          lvl_q[g] <= reg_wdata_i[g];
        end
      end
    end
  end

  // ***********************************************************************
  // Processor status word
  // ***********************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      psw_q <= `VIA_PSW_RESET;
    end else if (state_q == via_pkg::VIA_ST_PSW) begin
      psw_q[`VIA_ACCEPT_BIT] <= 1'b0;
      if (!sel_sw_q) begin
        psw_q[`VIA_INSVC_BIT] <= sel_lvl_q;
      end
    end else if (restore_i) begin
      psw_q <= restore_data_i;
    end else if (op_ei_i) begin
      psw_q[`VIA_ACCEPT_BIT] <= 1'b1;
    end else if (op_di_i) begin
      psw_q[`VIA_ACCEPT_BIT] <= 1'b0;
    end else if (wr_psw) begin
      psw_q <= (psw_q & ~reg_wmask_i[7:0])
               | (reg_wdata_i[7:0] & reg_wmask_i[7:0]);
    end
  end

  // ***********************************************************************
  // Entry sequencer
  // ***********************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= via_pkg::VIA_ST_IDLE;
      cnt_q <= 3'h0;
      sel_sw_q <= 1'b0;
      sel_lvl_q <= 1'b1;
      sel_idx_q <= '0;
      busy_q <= 1'b0;
    end else begin
      case (state_q)
        via_pkg::VIA_ST_IDLE: begin
          if (take_sw) begin
            state_q <= via_pkg::VIA_ST_WAIT;
            cnt_q <= WAIT_HI - 3'h1;
            sel_sw_q <= 1'b1;
            busy_q <= 1'b1;
          end else if (take_mk) begin
            state_q <= via_pkg::VIA_ST_WAIT;
            // Low level spends one more resolution clock
            cnt_q <= (pk.lvl_hit ? WAIT_LO : WAIT_HI) - 3'h1;
            sel_sw_q <= 1'b0;
            sel_lvl_q <= pk.lvl_hit;
            sel_idx_q <= pk.idx;
            busy_q <= 1'b1;
          end
        end
        via_pkg::VIA_ST_WAIT: begin
          if (cnt_q == 3'h0) begin
            state_q <= via_pkg::VIA_ST_PSW;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        via_pkg::VIA_ST_PSW: begin
          state_q <= via_pkg::VIA_ST_PC;
        end
        via_pkg::VIA_ST_PC: begin
          state_q <= via_pkg::VIA_ST_VEC;
        end
        via_pkg::VIA_ST_VEC: begin
          state_q <= via_pkg::VIA_ST_IDLE;
          busy_q <= 1'b0;
        end
        default: begin
          state_q <= via_pkg::VIA_ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // ***********************************************************************
  // Stack and vector strobes towards the core
  // ***********************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stk_wr_q <= 1'b0;
      stk_pc_q <= 1'b0;
      stk_data_q <= 8'h00;
      vec_load_q <= 1'b0;
      vec_addr_q <= 16'h0000;
    end else begin
      stk_wr_q <= (state_q == via_pkg::VIA_ST_PSW)
                  || (state_q == via_pkg::VIA_ST_PC);
      stk_pc_q <= (state_q == via_pkg::VIA_ST_PC);
      if (state_q == via_pkg::VIA_ST_PSW) begin
        stk_data_q <= psw_q;
      end
      vec_load_q <= (state_q == via_pkg::VIA_ST_VEC);
      if (state_q == via_pkg::VIA_ST_VEC) begin
        vec_addr_q <= sel_sw_q ? `VIA_TRAP_VECTOR
                    : 16'(VEC_BASE + VEC_STEP * 16'(sel_idx_q));
      end
    end
  end

  // ***********************************************************************
  // Register read-back
  // ***********************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 32'h00000000;
    end else begin
      case (reg_sel_i)
        `VIA_SEL_PSW: rdata_q <= {24'h000000, psw_q};
        `VIA_SEL_REQ: rdata_q <= 32'(req_q);
        `VIA_SEL_MASK: rdata_q <= 32'(mask_q);
        `VIA_SEL_LEVEL: rdata_q <= 32'(lvl_q);
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  assign reg_rdata_o = rdata_q;
  assign psw_o = psw_q;
  assign busy_o = busy_q;
  assign stk_wr_o = stk_wr_q;
  assign stk_pc_o = stk_pc_q;
  assign stk_data_o = stk_data_q;
  assign vec_load_o = vec_load_q;
  assign vec_addr_o = vec_addr_q;

endmodule // via_ack_top

`default_nettype wire

// *** sim/via_ack_checker.sv ***
/* Assertions on the entry sequence and status word of via_ack_top.
   Sees only the top's ports; bound to it at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module via_ack_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Core side
  input wire logic instr_end_i,
  input wire logic instr_hold_i,
  input wire logic op_brk_i,
  input wire logic op_ei_i,
  input wire logic op_di_i,
  input wire logic restore_i,
  input wire logic [7:0] restore_data_i,
  // Outputs watched
  input wire logic [7:0] psw_o,
  input wire logic busy_o,
  input wire logic stk_wr_o,
  input wire logic stk_pc_o,
  input wire logic vec_load_o,
  input wire logic [15:0] vec_addr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // *****
  // Entry
  // *****
  sequence s_hi;
    busy_o [*5] ##1 vec_load_o;
  endsequence
  sequence s_lo;
    busy_o [*6] ##1 vec_load_o;
  endsequence
  sequence s_push;
    (stk_wr_o && !stk_pc_o) ##1 (stk_wr_o && stk_pc_o && !psw_o[7])
      ##1 vec_load_o;
  endsequence
  property p_reset_psw;
    $fell(rst_i) |-> psw_o == 8'h02 && !busy_o;
  endproperty
  property p_lat;
    $rose(busy_o) |-> s_hi or s_lo;
  endproperty
  property p_cause;
    $rose(busy_o) |-> $past(instr_end_i) && ($past(op_brk_i) ||
      $past(psw_o[7]) && !$past(instr_hold_i));
  endproperty
  property p_trap;
    $rose(busy_o) && $past(op_brk_i) |->
      ##5 vec_load_o && vec_addr_o == 16'h003E;
  endproperty
  property p_order;
    stk_wr_o && !stk_pc_o |-> s_push;
  endproperty
  property p_vec_end;
    $fell(busy_o) |-> vec_load_o;
  endproperty
  property p_ei;
    op_ei_i && !restore_i && !busy_o |=> psw_o[7];
  endproperty
  property p_di;
    op_di_i && !op_ei_i && !restore_i && !busy_o |=> !psw_o[7];
  endproperty
  property p_restore;
    restore_i && !busy_o |=> psw_o == $past(restore_data_i);
  endproperty
  a_reset_psw: assert property (p_reset_psw)
    else $error("status word not at reset value");
  a_lat: assert property (p_lat)
    else $error("entry length wrong");
  a_cause: assert property (p_cause)
    else $error("entry without a valid decision");
  a_trap: assert property (p_trap)
    else $error("trap vector wrong");
  a_order: assert property (p_order)
    else $error("push order wrong");
  a_vec_end: assert property (p_vec_end)
    else $error("busy dropped without vector load");
  a_ei: assert property (p_ei)
    else $error("accept flag not set");
  a_di: assert property (p_di)
    else $error("accept flag not cleared");
  a_restore: assert property (p_restore)
    else $error("status word not restored");
endmodule // via_ack_checker

bind via_ack_top via_ack_checker via_ack_checker_i (.clk_i, .rst_i,
  .instr_end_i, .instr_hold_i, .op_brk_i, .op_ei_i, .op_di_i, .restore_i,
  .restore_data_i, .psw_o, .busy_o, .stk_wr_o, .stk_pc_o, .vec_load_o,
  .vec_addr_o);
`default_nettype wire

// *** sim/via_core_model.sv ***
/* Core-side stack model: keeps the pushed status word and flags a
   program counter push that comes without a status word first.
   Assumes the stack ports of via_ack_top on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module via_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pushes from the block
  input wire logic stk_wr_i,
  input wire logic stk_pc_i,
  input wire logic [7:0] stk_data_i,
  // Seen by the bench
  output logic [7:0] saved_psw_o,
  output logic order_err_o
);
  logic psw_seen_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      saved_psw_o <= 8'h00;
      psw_seen_q <= 1'b0;
      order_err_o <= 1'b0;
    end else if (stk_wr_i && !stk_pc_i) begin
      saved_psw_o <= stk_data_i;
      psw_seen_q <= 1'b1;
    end else if (stk_wr_i) begin
      order_err_o <= order_err_o | !psw_seen_q;
      psw_seen_q <= 1'b0;
    end
  end
endmodule // via_core_model
`default_nettype wire

// *** sim/via_ack_top_tb.sv ***
/* Self-checking bench of via_ack_top: instruction ends, register
   accesses and request pulses driven as the core would.
   Assumes via_core_model and the bound checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
  miscompares++; $display("Error %s expected %h seen %h", n, e, a); end end
module via_ack_top_tb;
  logic clk_i, rst_i, instr_end_i, instr_hold_i, op_brk_i, op_return_from_interrupt_i;
  logic op_return_from_trap_i, op_ei_i, op_di_i, reg_wr_i, reg_rd_i, restore_i;
  logic busy_o, stk_wr_o, stk_pc_o, vec_load_o, order_err;
  logic [7:0] src_req_i, restore_data_i, psw_o, stk_data_o, saved_psw;
  logic [31:0] reg_wdata_i, reg_wmask_i, reg_rdata_o;
  logic [15:0] vec_addr_o;
  via_pkg::via_sel_t reg_sel_i;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  via_ack_top #(.N_SRC(8)) via_ack_top_i (.clk_i, .rst_i, .src_req_i,
    .instr_end_i, .instr_hold_i, .op_brk_i, .op_return_from_interrupt_i, .op_return_from_trap_i,
    .op_ei_i, .op_di_i, .reg_wr_i, .reg_rd_i, .reg_sel_i, .reg_wdata_i,
    .reg_wmask_i, .restore_i, .restore_data_i, .reg_rdata_o, .psw_o,
    .busy_o, .stk_wr_o, .stk_pc_o, .stk_data_o, .vec_load_o, .vec_addr_o);
  via_core_model via_core_model_i (.clk_i, .rst_i, .stk_wr_i(stk_wr_o),
    .stk_pc_i(stk_pc_o), .stk_data_i(stk_data_o),
    .saved_psw_o(saved_psw), .order_err_o(order_err));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end
  // *****
  // Tasks
  // *****
  task automatic step();
    @(posedge clk_i);
    #2;
  endtask
  task automatic idle();
    {instr_end_i, instr_hold_i, op_brk_i, op_return_from_interrupt_i, op_return_from_trap_i} = '0;
    {op_ei_i, op_di_i, reg_wr_i, reg_rd_i, restore_i, src_req_i} = '0;
  endtask
  // Op bits: trap, accept on, accept off, return trap, return int
  task automatic ins(input logic [4:0] op, input logic [7:0] rd = 8'h00);
    {op_brk_i, op_ei_i, op_di_i, op_return_from_trap_i, op_return_from_interrupt_i} = op;
    {instr_end_i, instr_hold_i, restore_i} = {1'b1, |op[3:0], |op[1:0]};
    restore_data_i = rd;
    step();
    idle();
    step();
  endtask
  task automatic wreg(input via_pkg::via_sel_t s, input logic [31:0] d,
                      input logic [31:0] m);
    {reg_wr_i, instr_end_i, instr_hold_i} = 3'b111;
    {reg_sel_i, reg_wdata_i, reg_wmask_i} = {s, d, m};
    step();
    idle();
    step();
  endtask
  task automatic rreg(input via_pkg::via_sel_t s, input logic [31:0] e,
                      input string n);
    {reg_rd_i, instr_end_i, instr_hold_i} = 3'b111;
    reg_sel_i = s;
    step();
    idle();
    `CHK(n, e, reg_rdata_o)
    step();
  endtask
  task automatic pulse(input logic [7:0] v);
    src_req_i = v;
    step();
    idle();
    step();
  endtask
  // Count edges to the vector load; 12 means no entry
  task automatic ent(input logic [15:0] v, input int n);
    int k;
    k = 0;
    while (!vec_load_o && k < 12) begin
      step();
      k++;
    end
    `CHK("latency", n, k)
    if (k < 12) `CHK("vector", v, vec_addr_o)
    step();
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // *****
  // Tests
  // *****
  initial begin
    idle();
    {reg_sel_i, reg_wdata_i, reg_wmask_i, restore_data_i} = '0;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    #2 rst_i = 1'b0;
    rreg(2'h0, 32'h02, "status");
    rreg(2'h2, 32'hFF, "mask");
    rreg(2'h3, 32'hFF, "level");
    $display("Test reset done");
    ins(5'h08);
    pulse(8'h04);
    rreg(2'h1, 32'h04, "request");
    ins(5'h00);
    ent(16'h0, 12);
    wreg(2'h2, 32'h0, 32'h26);
    ent(16'h0, 12);
    ins(5'h00);
    ent(16'h0008, 5);
    `CHK("saved", 8'h82, saved_psw)
    `CHK("status", 8'h02, psw_o)
    $display("Test low level done");
    wreg(2'h3, 32'h0, 32'h20);
    pulse(8'h26);
    ins(5'h08);
    ent(16'h0, 12);
    ins(5'h00);
    ent(16'h000E, 4);
    `CHK("status", 8'h00, psw_o)
    ins(5'h08);
    ins(5'h00);
    ent(16'h0, 12);
    ins(5'h01, 8'h82);
    ent(16'h0, 12);
    `CHK("status", 8'h82, psw_o)
    ins(5'h00);
    ent(16'h0006, 5);
    ins(5'h01, 8'h82);
    ins(5'h00);
    ent(16'h0008, 5);
    $display("Test priority done");
    ins(5'h08);
    pulse(8'h04);
    ins(5'h10);
    ent(16'h003E, 4);
    `CHK("saved", 8'h82, saved_psw)
    ins(5'h00);
    ent(16'h0, 12);
    ins(5'h02, 8'h82);
    ins(5'h00);
    ent(16'h0008, 5);
    $display("Test trap done");
    wreg(2'h0, 32'hFF, 32'h80);
    rreg(2'h0, 32'h82, "status");
    ins(5'h04);
    `CHK("status", 8'h02, psw_o)
    pulse(8'h04);
    ins(5'h00);
    ent(16'h0, 12);
    ins(5'h08);
    ins(5'h00);
    ent(16'h0008, 5);
    pulse(8'h02);
    wreg(2'h1, 32'h0, 32'h02);
    rreg(2'h1, 32'h00, "request");
    ins(5'h08);
    ins(5'h00);
    ent(16'h0, 12);
    `CHK("order", 1'b0, order_err)
    $display("Test status word done");
    finish_test();
  end
endmodule // via_ack_top_tb
`default_nettype wire
